// *** design/pstc_map.svh ***
`ifndef PSTC_MAP_SVH
`define PSTC_MAP_SVH

// Register byte offsets on the Wishbone slave
`define PSTC_OFF_FIRST_MODE 8'h00
`define PSTC_OFF_SECOND_MODE 8'h04
`define PSTC_OFF_THIRD_MODE 8'h08
`define PSTC_OFF_TDO_DATA 8'h0C
`define PSTC_OFF_TDI_DATA 8'h10
`define PSTC_OFF_STATUS 8'h14

// Reset values
`define PSTC_RST_MODE 8'h00
`define PSTC_RST_BYTE 8'h00

// first_mode_word fields
`define PSTC_F1_TDO_EN 3
`define PSTC_F1_TDI_EN 4
`define PSTC_F1_TCK_RUN 5
// second_mode_word fields
`define PSTC_F2_STOP_EMPTY 3
`define PSTC_F2_STOP_FULL 4
// third_mode_word fields
`define PSTC_F3_FREE_IN 0

// Status fields
`define PSTC_ST_TDO_ROOM 0
`define PSTC_ST_TDI_VALID 1
`define PSTC_ST_TCK_ON 2
`define PSTC_ST_REFUSED 3
`define PSTC_ST_OVERRUN 4
`define PSTC_ST_CNT_LSB 5

// Bit position of the last bit of a byte
`define PSTC_LAST_BIT 3'h7

`endif

// *** design/pstc_pkg.sv ***
package pstc_pkg;

	// Double-buffered shifter/buffer state
	typedef struct packed {
		logic [7:0] hold;
		logic hold_full;
		logic [7:0] sh;
		logic sh_valid;
		logic [7:0] cap;
		logic cap_full;
	} pstc_shf_t;

	// Host bus domain state
	typedef struct packed {
		logic [7:0] second_mode_word;
		logic [7:0] third_mode_word;
		logic [7:0] mode3;
		logic [7:0] tdo_byte;
		logic tdo_req;
		logic tdi_ack;
		logic refused;
		logic overrun;
		logic ovr_seen;
		logic ack;
		logic [31:0] dat;
	} pstc_bus_t;

	// Link (scan clock) domain state
	typedef struct packed {
		logic [2:0] bit_cnt;
		logic [2:0] cnt_gray;
		logic tdo_ack;
		logic tdi_req;
		logic [7:0] tdi_byte;
		logic ovr_tgl;
		logic tdo_pin;
	} pstc_lnk_t;

endpackage : pstc_pkg

// *** design/pstc_shift_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Engine side steers shifting; buffer side holds the two byte halves
interface pstc_shift_if;
	logic shift;
	logic boundary;
	logic sin;
	logic sout;
	logic [7:0] load_data;
	logic load_valid;
	logic load_ready;
	logic [7:0] cap_data;
	logic cap_full;
	logic cap_pop;
	logic sh_valid;

	modport engine (
		output shift, boundary, sin, load_data, load_valid, cap_pop,
		input sout, load_ready, cap_data, cap_full, sh_valid
	);
	modport buffer (
		input shift, boundary, sin, load_data, load_valid, cap_pop,
		output sout, load_ready, cap_data, cap_full, sh_valid
	);
endinterface : pstc_shift_if

`default_nettype wire

// *** design/pstc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a change is passed once stages two and three agree
module pstc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} pstc_sync_t;

	pstc_sync_t s;
	pstc_sync_t next_s;

	// Stage one feeds only stage two
	always_comb begin
		next_s = s;
		next_s.s1 = din;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		for (int i = 0; i < W; i++) begin
			if (s.s2[i] == s.s3[i]) begin
				next_s.q[i] = s.s3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.q;
endmodule : pstc_sync

`default_nettype wire

// *** design/pstc_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none

// One shifter/buffer: a parallel hold half and a serial shift half
module pstc_shifter (
	input wire logic clk,
	input wire logic rst_b,
	pstc_shift_if.buffer bus
);
	pstc_pkg::pstc_shf_t s;
	pstc_pkg::pstc_shf_t next_s;

	// Serial bits enter at the top and leave at the bottom, LSB first
	always_comb begin
		next_s = s;
		if (bus.cap_pop) begin
			next_s.cap_full = 1'b0;
		end
		if (bus.shift) begin
			next_s.sh = {bus.sin, s.sh[7:1]};
			if (bus.boundary) begin
				// While shifting, halves exchange only at the shared byte boundary
				next_s.cap = {bus.sin, s.sh[7:1]};
				next_s.cap_full = 1'b1; // Capture wins over a pop in the same cycle
				next_s.sh = s.hold;
				next_s.sh_valid = s.hold_full;
				next_s.hold_full = 1'b0;
			end
		end else if (!s.sh_valid && s.hold_full) begin
			// Idle shift half is preloaded, so a later enable starts mid-byte
			next_s.sh = s.hold;
			next_s.sh_valid = 1'b1;
			next_s.hold_full = 1'b0;
		end
		if (bus.load_valid && !s.hold_full) begin
			next_s.hold = bus.load_data;
			next_s.hold_full = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bus.sout = s.sh[0];
	assign bus.load_ready = !s.hold_full;
	assign bus.cap_data = s.cap;
	assign bus.cap_full = s.cap_full;
	assign bus.sh_valid = s.sh_valid;
endmodule : pstc_shifter

`default_nettype wire

// *** design/pstc_scan_tck.sv ***
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pstc_map.svh"

module pstc_scan_tck (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic scan_clk,
	input wire logic tdi,
	output logic tck,
	output logic tdo
);
	// Word address match for the register decoder
	function automatic logic pstc_hit(input logic [7:0] adr, input logic [7:0] off);
		pstc_hit = (adr[7:2] == off[7:2]);
	endfunction : pstc_hit

	// Gray code of a bit position, so the count can cross one bit at a time
	function automatic logic [2:0] pstc_gray(input logic [2:0] bin);
		pstc_gray = bin ^ {1'b0, bin[2:1]};
	endfunction : pstc_gray

	pstc_pkg::pstc_bus_t b;
	pstc_pkg::pstc_bus_t next_b;
	pstc_pkg::pstc_lnk_t l;
	pstc_pkg::pstc_lnk_t next_l;
	logic gate;
	logic next_gate;

	pstc_shift_if out_if ();
	pstc_shift_if in_if ();

	pstc_shifter u_out_buf (
		.clk(scan_clk),
		.rst_b(rst_b),
		.bus(out_if.buffer)
	);

	pstc_shifter u_in_buf (
		.clk(scan_clk),
		.rst_b(rst_b),
		.bus(in_if.buffer)
	);

	// ------------------------------------------------------------------
	// Crossings: mode bits and handshake toggles go to the link side,
	// answers and status come back to the host side
	// ------------------------------------------------------------------
	logic [7:0] to_lnk;
	logic [7:0] at_lnk;
	logic [6:0] to_bus;
	logic [6:0] at_bus;

	assign to_lnk = {b.second_mode_word[`PSTC_F1_TCK_RUN], b.second_mode_word[`PSTC_F1_TDI_EN],
		b.second_mode_word[`PSTC_F1_TDO_EN], b.third_mode_word[`PSTC_F2_STOP_FULL],
		b.third_mode_word[`PSTC_F2_STOP_EMPTY], b.mode3[`PSTC_F3_FREE_IN], b.tdi_ack, b.tdo_req};
	assign to_bus = {l.cnt_gray, l.ovr_tgl, gate, l.tdi_req, l.tdo_ack};

	pstc_sync #(.W(8)) u_sync_lnk (
		.clk(scan_clk),
		.rst_b(rst_b),
		.din(to_lnk),
		.dout(at_lnk)
	);

	pstc_sync #(.W(7)) u_sync_bus (
		.clk(core_clk),
		.rst_b(rst_b),
		.din(to_bus),
		.dout(at_bus)
	);

	// Link-side views of the mode words; host keeps them still while the clock runs
	logic l_tck_run;
	logic l_tdi_en;
	logic l_tdo_en;
	logic l_stop_full;
	logic l_stop_empty;
	logic l_free_in;
	logic l_tdi_ack;
	logic l_tdo_req;
	assign {l_tck_run, l_tdi_en, l_tdo_en, l_stop_full, l_stop_empty, l_free_in,
		l_tdi_ack, l_tdo_req} = at_lnk;

	// Host-side views of link answers
	logic [2:0] h_cnt_gray;
	logic h_ovr_tgl;
	logic h_tck_on;
	logic h_tdi_req;
	logic h_tdo_ack;
	assign {h_cnt_gray, h_ovr_tgl, h_tck_on, h_tdi_req, h_tdo_ack} = at_bus;

	// ------------------------------------------------------------------
	// Link domain: bit counter, shift steering and buffer handshakes
	// ------------------------------------------------------------------
	logic at_boundary;
	logic shift_permit;
	logic out_stall;
	logic in_stall;
	logic tdo_pending;
	logic tdi_free;

	always_comb begin
		at_boundary = (l.bit_cnt == `PSTC_LAST_BIT);
		// Unless l_free_in is set, input may shift only while the capture half can take the byte in progress
		shift_permit = l_tdi_en && (l_free_in || !(in_if.cap_full && at_boundary));
		in_stall = l_tdi_en && l_stop_full && !shift_permit;
		// With l_stop_empty set, output stalls rather than underflow when nothing is left to send
		out_stall = l_tdo_en && l_stop_empty && !out_if.sh_valid;
		next_gate = l_tck_run && !out_stall && !in_stall;
		tdo_pending = (l_tdo_req != l.tdo_ack);
		tdi_free = (l.tdi_req == l_tdi_ack);
	end

	// Engine drives both shifter/buffers from the one shared counter
	assign out_if.shift = gate && l_tdo_en;
	assign out_if.boundary = gate && at_boundary;
	assign out_if.sin = 1'b0;
	assign out_if.load_data = b.tdo_byte;
	assign out_if.load_valid = tdo_pending;
	assign out_if.cap_pop = 1'b1;
	assign in_if.shift = gate && shift_permit;
	assign in_if.boundary = gate && at_boundary;
	assign in_if.sin = tdi;
	assign in_if.load_data = `PSTC_RST_BYTE;
	assign in_if.load_valid = 1'b0;
	assign in_if.cap_pop = in_if.cap_full && tdi_free;

	// Link state update
	always_comb begin
		next_l = l;
		if (gate) begin
			next_l.bit_cnt = l.bit_cnt + 3'h1;
		end
		next_l.cnt_gray = pstc_gray(next_l.bit_cnt);
		// Host byte is stable until the toggle returns, so it is read directly
		if (tdo_pending && out_if.load_ready) begin
			next_l.tdo_ack = ~l.tdo_ack;
		end
		if (in_if.cap_pop) begin
			next_l.tdi_byte = in_if.cap_data;
			next_l.tdi_req = ~l.tdi_req;
		end
		// A capture onto a full half that nobody drained is an overrun
		if (in_if.shift && in_if.boundary && in_if.cap_full && !in_if.cap_pop) begin
			next_l.ovr_tgl = ~l.ovr_tgl;
		end
		next_l.tdo_pin = out_if.shift ? out_if.sout : l.tdo_pin;
	end

	always_ff @(posedge scan_clk or negedge rst_b) begin
		if (!rst_b) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// Gate changes only while the scan clock is low, so the test clock never glitches
	always_ff @(negedge scan_clk or negedge rst_b) begin
		if (!rst_b) begin
			gate <= 1'b0;
		end else begin
			gate <= next_gate;
		end
	end

	// Targets load on this rising edge and present on the falling one
	assign tck = scan_clk & gate;
	assign tdo = l.tdo_pin;

	// ------------------------------------------------------------------
	// Host domain: classic Wishbone slave, one wait state per access
	// ------------------------------------------------------------------
	logic access;
	logic tdo_busy;
	logic tdi_valid;
	logic [2:0] cnt_bin;

	always_comb begin
		access = wb_cyc_i && wb_stb_i && !b.ack;
		tdo_busy = (b.tdo_req != h_tdo_ack);
		tdi_valid = (h_tdi_req != b.tdi_ack);
		cnt_bin = {h_cnt_gray[2], h_cnt_gray[2] ^ h_cnt_gray[1],
			h_cnt_gray[2] ^ h_cnt_gray[1] ^ h_cnt_gray[0]};
	end

	always_comb begin
		next_b = b;
		next_b.ack = access;
		next_b.ovr_seen = h_ovr_tgl;
		if (!access) begin
			next_b.dat = 32'h0000_0000;
		end
		if (access && wb_we_i) begin
			if (pstc_hit(wb_adr_i, `PSTC_OFF_FIRST_MODE)) begin
				if (wb_sel_i[0]) next_b.second_mode_word = wb_dat_i[7:0];
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_SECOND_MODE)) begin
				if (wb_sel_i[0]) next_b.third_mode_word = wb_dat_i[7:0];
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_THIRD_MODE)) begin
				if (wb_sel_i[0]) next_b.mode3 = wb_dat_i[7:0];
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_TDO_DATA)) begin
				// A byte written while the last one is still crossing is refused
				if (wb_sel_i[0] && !tdo_busy) begin
					next_b.tdo_byte = wb_dat_i[7:0];
					next_b.tdo_req = ~b.tdo_req;
				end else if (wb_sel_i[0]) begin
					next_b.refused = 1'b1;
				end
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_STATUS)) begin
				// Write one to clear the sticky flags
				if (wb_sel_i[0] && wb_dat_i[`PSTC_ST_REFUSED]) next_b.refused = 1'b0;
				if (wb_sel_i[0] && wb_dat_i[`PSTC_ST_OVERRUN]) next_b.overrun = 1'b0;
			end
		end
		if (access && !wb_we_i) begin
			next_b.dat = 32'h0000_0000;
			if (pstc_hit(wb_adr_i, `PSTC_OFF_FIRST_MODE)) begin
				next_b.dat[7:0] = b.second_mode_word;
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_SECOND_MODE)) begin
				next_b.dat[7:0] = b.third_mode_word;
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_THIRD_MODE)) begin
				next_b.dat[7:0] = b.mode3;
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_TDI_DATA)) begin
				// Reading a waiting byte frees the link to send the next
				if (tdi_valid) begin
					next_b.dat[7:0] = l.tdi_byte;
					next_b.tdi_ack = ~b.tdi_ack;
				end
			end else if (pstc_hit(wb_adr_i, `PSTC_OFF_STATUS)) begin
				next_b.dat[`PSTC_ST_TDO_ROOM] = !tdo_busy;
				next_b.dat[`PSTC_ST_TDI_VALID] = tdi_valid;
				next_b.dat[`PSTC_ST_TCK_ON] = h_tck_on;
				next_b.dat[`PSTC_ST_REFUSED] = b.refused;
				next_b.dat[`PSTC_ST_OVERRUN] = b.overrun;
				next_b.dat[`PSTC_ST_CNT_LSB +: 3] = cnt_bin;
			end
		end
		// Hardware set wins over a clear in the same cycle
		if (h_ovr_tgl != b.ovr_seen) begin
			next_b.overrun = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			b <= '0;
		end else begin
			b <= next_b;
		end
	end

	assign wb_ack_o = b.ack;
	assign wb_dat_o = b.dat;
endmodule : pstc_scan_tck

`default_nettype wire

// *** dv/pstc_scan_tck_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the bus answer and the gated test clock
module pstc_scan_tck_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic scan_clk,
	input wire logic tdi,
	input wire logic tck,
	input wire logic tdo
);
	// One ack per taken request, dropped the next cycle
	property p_ack_once;
		@(posedge core_clk) disable iff (!rst_b)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

	property p_ack_cause;
		@(posedge core_clk) disable iff (!rst_b)
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

	property p_dat_idle;
		@(posedge core_clk) disable iff (!rst_b)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");

	// Gating only removes pulses, so the test clock is low whenever the scan clock is
	property p_tck_low;
		@(posedge core_clk) disable iff (!rst_b)
		!scan_clk |-> !tck;
	endproperty
	a_tck_low: assert property (p_tck_low) else $error("tck high with scan clock low");

	property p_tck_edge;
		@(posedge core_clk) disable iff (!rst_b)
		$changed(tck) |-> $changed(scan_clk);
	endproperty
	a_tck_edge: assert property (p_tck_edge) else $error("tck moved alone");

	// Output bit moves only in a cycle that had a test clock pulse
	property p_tdo_gate;
		@(negedge scan_clk) disable iff (!rst_b)
		$changed(tdo) |-> tck;
	endproperty
	a_tdo_gate: assert property (p_tdo_gate) else $error("tdo moved without tck");
endmodule : pstc_scan_tck_chk

bind pstc_scan_tck pstc_scan_tck_chk i_chk (.core_clk(core_clk), .rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.scan_clk(scan_clk), .tdi(tdi), .tck(tck), .tdo(tdo));

`default_nettype wire

// *** dv/pstc_chain_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Scan chain of LEN cells between our tdo and tdi
module pstc_chain_model #(
	parameter int LEN = 7
) (
	input wire logic tck,
	input wire logic tdo_in,
	output logic tdo_out
);
	logic [LEN-1:0] cells = '0;

	initial tdo_out = 1'b0;
	// Cells load on the rising test clock
	always @(posedge tck) cells <= {cells[LEN-2:0], tdo_in};
	// Last cell reaches the chain output on the falling edge
	always @(negedge tck) tdo_out <= cells[LEN-1];
endmodule : pstc_chain_model

`default_nettype wire

// *** dv/test_pstc_scan_tck.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pstc_map.svh"

module test_pstc_scan_tck;
	logic core_clk = 1'b0;
	logic scan_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic tdi;
	logic tck;
	logic tdo;
	logic [31:0] q;
	int failures = 0;
	int checked = 0;
	int tck_n = 0;
	int c;
	int sent;
	int got;

	pstc_scan_tck i_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_clk(scan_clk),
		.tdi(tdi), .tck(tck), .tdo(tdo));
	pstc_chain_model i_chain (.tck(tck), .tdo_in(tdo), .tdo_out(tdi));

	// Clocks; scan clock offset so its edges never meet core edges
	always #20 core_clk = ~core_clk;
	initial begin
		#7;
		forever #62.5 scan_clk = ~scan_clk;
	end
	always @(posedge tck) tck_n++;

	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		checked++;
		if (got_v !== exp_v) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
		end
	endtask : chk

	// Classic single cycle; waits for ack, data taken at that edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	// Count test clock pulses over n scan cycles
	task automatic span(input int n);
		int s;
		@(negedge scan_clk);
		s = tck_n;
		repeat (n) @(negedge scan_clk);
		c = tck_n - s;
	endtask : span

	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	// Watchdog well beyond the expected run time
	initial begin
		#200000;
		failures++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		chk({30'h0, tck, tdo}, 32'h0000_0000);
		repeat (3) @(posedge scan_clk);
		@(posedge core_clk);
		rst_b <= 1'b1;
		// Reset values, unmapped place, mode words written with tck off
		wb(1'b0, `PSTC_OFF_FIRST_MODE, 8'h00);
		chk(q, 32'h0000_0000);
		wb(1'b1, 8'h40, 8'hFF);
		wb(1'b0, 8'h40, 8'h00);
		chk(q, 32'h0000_0000);
		wb(1'b1, `PSTC_OFF_SECOND_MODE, 8'h18);
		wb(1'b0, `PSTC_OFF_SECOND_MODE, 8'h00);
		chk(q, 32'h0000_0018);
		wb(1'b1, `PSTC_OFF_THIRD_MODE, 8'h01);
		wb(1'b0, `PSTC_OFF_THIRD_MODE, 8'h00);
		chk(q, 32'h0000_0001);
		wb(1'b1, `PSTC_OFF_THIRD_MODE, 8'h00);
		$display("test regs done");
		// Free-running test clock with no stall modes
		wb(1'b1, `PSTC_OFF_SECOND_MODE, 8'h00);
		wb(1'b1, `PSTC_OFF_FIRST_MODE, 8'h20);
		repeat (8) @(posedge scan_clk);
		span(16);
		chk(c, 32'd16);
		wb(1'b0, `PSTC_OFF_STATUS, 8'h00);
		chk(q[2], 1'b1);
		wb(1'b1, `PSTC_OFF_FIRST_MODE, 8'h00);
		repeat (8) @(posedge scan_clk);
		span(16);
		chk(c, 32'd0);
		$display("test clock done");
		// A second byte while the first is still crossing is refused; flag clears by W1C
		wb(1'b1, `PSTC_OFF_TDO_DATA, 8'hA5);
		wb(1'b1, `PSTC_OFF_TDO_DATA, 8'hA5);
		wb(1'b0, `PSTC_OFF_STATUS, 8'h00);
		chk(q[3], 1'b1);
		wb(1'b1, `PSTC_OFF_STATUS, 8'h08);
		wb(1'b0, `PSTC_OFF_STATUS, 8'h00);
		chk(q[3], 1'b0);
		$display("test refuse done");
		// Stream through the chain with both stop modes on
		wb(1'b1, `PSTC_OFF_SECOND_MODE, 8'h18);
		wb(1'b1, `PSTC_OFF_FIRST_MODE, 8'h38);
		sent = 1;
		got = 0;
		while (got < 6) begin
			wb(1'b0, `PSTC_OFF_STATUS, 8'h00);
			c = q[1:0];
			if (c[0] && sent < 8) begin
				wb(1'b1, `PSTC_OFF_TDO_DATA, 8'hA5);
				sent++;
			end
			if (c[1]) begin
				wb(1'b0, `PSTC_OFF_TDI_DATA, 8'h00);
				got++;
			end
		end
		chk(q, 32'h0000_00A5);
		span(40);
		span(16);
		chk(c, 32'd0);
		wb(1'b1, `PSTC_OFF_FIRST_MODE, 8'h00);
		$display("test stream done");
		finish_test();
	end
endmodule : test_pstc_scan_tck

`default_nettype wire
